// ### mcaux_pkg.sv
//////////////////////////////////////////////////////////////////////
// Behaviour
// - Core drives its own 16-bit flag copy
// - Flags active low, reset to one
// - Unlocked core forces all flags inactive
// - Interrupt-set instruction drives host interrupt request
// - Subroutine jump captures program counter
// - Offset compensation switchable, first four converters
// - Fourth low offset reused high; negative none
// - Gain-select instruction changes shunt amplifier gain
// - ADC request enters conversion, no comparisons
// - Status word written whole or single bit
// - Backdoor address from own register or index
// - Backdoor reaches SPI registers, not RAMs
// - Read: load address, issue, result to data
// - Write: load address and data, then issue
// - Two-cycle operation; locations held while busy
// - Idle backdoor locations serve as spare storage
// - Write dropped if target locked at issue
// - Per-output fields written only where granted
// - Filter fields written only for granted converters
// - Converter and boost threshold registers refused
// - Converter drive mode needs low-side grant
// - End-of-actuation mode, optional source threshold zero
// - Conversion result visible in converter access mode
//////////////////////////////////////////////////////////////////////
package mcaux_pkg;
  localparam int FLAG_W = 16;
  localparam int STAT_W = 16;
  localparam int PC_W = 10;
  localparam int BDA_W = 8;
  localparam int BDD_W = 16;
  localparam int N_HS = 5;
  localparam int N_LS = 7;
  localparam int N_OUT = 12;
  localparam int N_CONV = 4;
  localparam int THR_W = 3;
  localparam int SLEW_W = 2;
  localparam int GAIN_W = 2;
  localparam int FLT_W = 8;
  localparam int BFLT_W = 13;
  localparam int LS1_N = 5;
  localparam int BD_CYCLES = 2;
  localparam int GRANT_LS7 = 11;
  localparam int CG_BOOST = 4;
  localparam int CG_EOA_AUTO = 5;
  localparam int CG_W = 6;
  localparam logic [FLAG_W-1:0] FLAG_RST = 16'hffff;
  localparam logic [1:0] DAM_DAC = 2'h0;
  localparam logic [1:0] DAM_OFFS = 2'h1;
  localparam logic [1:0] DAM_FULL = 2'h2;
  localparam logic [11:0] A_OUT_GRANT = 12'h000;
  localparam logic [11:0] A_CUR_GRANT = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h008;
  localparam logic [11:0] A_FLAGS = 12'h00c;
  localparam logic [11:0] A_RET_PC = 12'h010;
  localparam logic [11:0] A_BDOOR = 12'h014;
  localparam logic [11:0] A_MEAS = 12'h018;
  localparam logic [7:0] BA_BIAS = 8'h88;
  localparam logic [7:0] BA_VDS_HS = 8'h8a;
  localparam logic [7:0] BA_VSRC_HS = 8'h8b;
  localparam logic [7:0] BA_VDS_LS1 = 8'h8c;
  localparam logic [7:0] BA_VDS_LS2 = 8'h8d;
  localparam logic [7:0] BA_HS_SLEW = 8'h8e;
  localparam logic [7:0] BA_LS_SLEW = 8'h8f;
  localparam logic [7:0] BA_CF12 = 8'h98;
  localparam logic [7:0] BA_CF34L = 8'h99;
  localparam logic [7:0] BA_CF4H4N = 8'h9a;
  localparam logic [7:0] BA_BOOST_DAC = 8'h9b;
  localparam logic [7:0] BA_BOOST_FLT = 8'h9d;
  localparam logic [7:0] BA_DAC_LO = 8'ha0;
  localparam logic [7:0] BA_DAC_HI = 8'ha5;
  typedef enum logic [3:0] {
    OP_NONE, OP_FLAGS, OP_IRQ, OP_JSR, OP_OFFC, OP_GAIN, OP_ADC, OP_STATUS,
    OP_ASRC, OP_BD_ADDR, OP_BD_DATA, OP_BD_RD, OP_BD_WR, OP_DACMODE, OP_DCDC, OP_EOA
  } mcaux_op_t;
  typedef struct packed {
    mcaux_op_t op;
    logic single;
    logic [3:0] bit_sel;
    logic [15:0] data;
  } mcaux_cmd_t;
  typedef struct packed {
    logic [N_CONV-1:0] oc_en;
    logic oc_4h;
    logic oc_4neg;
    logic [GAIN_W-1:0] gain;
    logic adc_mode;
    logic thr_cmp_en;
    logic adc_view;
  } mcaux_cm_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [BDA_W-1:0] addr;
    logic [BDD_W-1:0] wdata;
    logic [BDD_W-1:0] wmask;
  } mcaux_bd_t;
endpackage

// ### mcaux_core.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module mcaux_core
  import mcaux_pkg::*;
#(
  parameter int N_OTHER = 3
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mcaux_cmd_t cmd,
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [BDA_W-1:0] index_reg,
  input wire logic core_unlocked,
  input wire logic [N_OTHER-1:0] other_irq,
  input wire logic spi_target_locked,
  input wire logic [BDD_W-1:0] spi_rdata,
  output logic [FLAG_W-1:0] flags_n,
  output logic irq,
  output logic host_interrupt_pin_n,
  output logic [PC_W-1:0] ret_pc,
  output logic [STAT_W-1:0] status_bits,
  output mcaux_cm_t cm_ctrl,
  output mcaux_bd_t bd,
  output logic bd_busy,
  output logic [BDA_W-1:0] bd_addr_reg,
  output logic [BDD_W-1:0] bd_data_reg,
  output logic dcdc_mode,
  output logic eoa_mode,
  output logic hs_src_thr_zero
);
  if (N_OTHER < 1)
  begin : g_bad_other
    $error("N_OTHER must be at least one");
  end

  //////////////////////////////////////////////////////////////////////
  // Internal registers and signals
  logic [FLAG_W-1:0] flags_q;
  logic [N_OUT-1:0] out_grant;
  logic [CG_W-1:0] cur_grant;
  logic asrc_index;
  logic [1:0] dac_mode;
  logic [GAIN_W-1:0] gain_q;
  logic [N_CONV-1:0] oc_q;
  logic adc_q;
  typedef enum logic [1:0] {BD_IDLE, BD_ACT, BD_DONE} mcaux_bd_st_t;
  mcaux_bd_st_t bd_st;
  logic bd_wr_q;
  logic bd_ok;
  logic [BDD_W-1:0] bd_mask_q;
  logic [BDD_W-1:0] next_mask;
  logic refused;
  logic [BDA_W-1:0] bd_sel_addr;

  //////////////////////////////////////////////////////////////////////
  // Flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= FLAG_RST;
    else if (cmd.op == OP_FLAGS)
    begin
      if (cmd.single)
        flags_q[cmd.bit_sel] <= cmd.data[0];
      else
        flags_q <= cmd.data;
    end
  end

  assign flags_n = core_unlocked ? FLAG_RST : flags_q;

  //////////////////////////////////////////////////////////////////////
  // Interrupt, subroutine, status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else if (cmd.op == OP_IRQ)
      irq <= cmd.data[0];
  end

  assign host_interrupt_pin_n = ~(irq | (|other_irq));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ret_pc <= '0;
    else if (cmd.op == OP_JSR)
      ret_pc <= program_counter;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_bits <= '0;
    else if (cmd.op == OP_STATUS)
    begin
      if (cmd.single)
        status_bits[cmd.bit_sel] <= cmd.data[0];
      else
        status_bits <= cmd.data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Current measure control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oc_q <= '0;
      gain_q <= '0;
      adc_q <= 1'b0;
      dac_mode <= DAM_FULL;
    end
    else
    begin
      if (cmd.op == OP_OFFC)
        oc_q <= cmd.data[N_CONV-1:0];
      if (cmd.op == OP_GAIN)
        gain_q <= cmd.data[GAIN_W-1:0];
      if (cmd.op == OP_ADC)
        adc_q <= cmd.data[0];
      if (cmd.op == OP_DACMODE)
        dac_mode <= cmd.data[1:0];
    end
  end

  always_comb
  begin
    cm_ctrl.oc_en = oc_q;
    cm_ctrl.oc_4h = oc_q[N_CONV-1];
    cm_ctrl.oc_4neg = 1'b0;
    cm_ctrl.gain = gain_q;
    cm_ctrl.adc_mode = adc_q;
    cm_ctrl.thr_cmp_en = ~adc_q;
    cm_ctrl.adc_view = adc_q & (dac_mode == DAM_DAC);
  end

  //////////////////////////////////////////////////////////////////////
  // Converter drive and end of actuation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dcdc_mode <= 1'b0;
      eoa_mode <= 1'b0;
    end
    else
    begin
      if (cmd.op == OP_DCDC && out_grant[GRANT_LS7])
        dcdc_mode <= cmd.data[0];
      if (cmd.op == OP_EOA)
        eoa_mode <= cmd.data[0];
    end
  end

  assign hs_src_thr_zero = eoa_mode & cur_grant[CG_EOA_AUTO];

  //////////////////////////////////////////////////////////////////////
  // Backdoor locations and address source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      asrc_index <= 1'b0;
    else if (cmd.op == OP_ASRC)
      asrc_index <= cmd.data[0];
  end

  assign bd_sel_addr = asrc_index ? index_reg : bd_addr_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bd_addr_reg <= '0;
    else if (cmd.op == OP_BD_ADDR && !bd_busy)
      bd_addr_reg <= cmd.data[BDA_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bd_data_reg <= '0;
    else if (bd_st == BD_DONE && !bd_wr_q)
      bd_data_reg <= bd_ok ? spi_rdata : '0;
    else if (cmd.op == OP_BD_DATA && !bd_busy)
      bd_data_reg <= cmd.data;
  end

  //////////////////////////////////////////////////////////////////////
  // Access masks
  logic [BDD_W-1:0] m_vds_hs;
  logic [BDD_W-1:0] m_vds_ls1;
  logic [BDD_W-1:0] m_vds_ls2;
  logic [BDD_W-1:0] m_hs_slew;
  logic [BDD_W-1:0] m_ls_slew;

  always_comb
  begin
    m_vds_hs = '0;
    m_vds_ls1 = '0;
    m_vds_ls2 = '0;
    m_hs_slew = '0;
    m_ls_slew = '0;
    for (int i = 0; i < N_HS; i++)
    begin
      m_vds_hs[i*THR_W +: THR_W] = {THR_W{out_grant[i]}};
      m_hs_slew[i*SLEW_W +: SLEW_W] = {SLEW_W{out_grant[i]}};
    end
    for (int i = 0; i < N_LS; i++)
    begin
      m_ls_slew[i*SLEW_W +: SLEW_W] = {SLEW_W{out_grant[N_HS+i]}};
      if (i < LS1_N)
        m_vds_ls1[i*THR_W +: THR_W] = {THR_W{out_grant[N_HS+i]}};
      else
        m_vds_ls2[(i-LS1_N)*THR_W +: THR_W] = {THR_W{out_grant[N_HS+i]}};
    end
  end

  always_comb
  begin
    next_mask = '0;
    refused = 1'b0;
    case (bd_sel_addr)
      BA_VDS_HS, BA_VSRC_HS: next_mask = m_vds_hs;
      BA_VDS_LS1: next_mask = m_vds_ls1;
      BA_VDS_LS2: next_mask = m_vds_ls2;
      BA_HS_SLEW: next_mask = m_hs_slew;
      BA_LS_SLEW: next_mask = m_ls_slew;
      BA_BIAS: next_mask = {{(BDD_W-N_OUT){1'b0}}, out_grant};
      BA_CF12: next_mask = {{FLT_W{cur_grant[1]}}, {FLT_W{cur_grant[0]}}};
      BA_CF34L: next_mask = {{FLT_W{cur_grant[3]}}, {FLT_W{cur_grant[2]}}};
      BA_CF4H4N: next_mask = {BDD_W{cur_grant[3]}};
      BA_BOOST_FLT: next_mask = {{(BDD_W-BFLT_W){1'b0}}, {BFLT_W{cur_grant[CG_BOOST]}}};
      BA_BOOST_DAC: refused = 1'b1;
      default:
      begin
        next_mask = {BDD_W{1'b1}};
        refused = (bd_sel_addr >= BA_DAC_LO) && (bd_sel_addr <= BA_DAC_HI);
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Backdoor sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bd_st <= BD_IDLE;
      bd_wr_q <= 1'b0;
      bd_ok <= 1'b0;
      bd_mask_q <= '0;
    end
    else
    begin
      case (bd_st)
        BD_IDLE:
        begin
          if ((cmd.op == OP_BD_RD) || (cmd.op == OP_BD_WR))
          begin
            bd_st <= BD_ACT;
            bd_wr_q <= (cmd.op == OP_BD_WR);
            bd_ok <= !refused && !((cmd.op == OP_BD_WR) && spi_target_locked);
            bd_mask_q <= next_mask;
          end
        end
        BD_ACT: bd_st <= BD_DONE;
        BD_DONE: bd_st <= BD_IDLE;
        default: bd_st <= BD_IDLE;
      endcase
    end
  end

  assign bd_busy = (bd_st != BD_IDLE);

  always_comb
  begin
    bd.addr = bd_sel_addr;
    bd.wdata = bd_data_reg;
    bd.wmask = bd_mask_q;
    bd.req = (bd_st == BD_ACT) && bd_ok;
    bd.we = (bd_st == BD_ACT) && bd_ok && bd_wr_q;
  end

  //////////////////////////////////////////////////////////////////////
  // APB slave
  logic setup;
  logic mapped;

  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign mapped = (paddr == A_OUT_GRANT) || (paddr == A_CUR_GRANT) || (paddr == A_STATUS)
    || (paddr == A_FLAGS) || (paddr == A_RET_PC) || (paddr == A_BDOOR) || (paddr == A_MEAS);
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_grant <= '0;
      cur_grant <= '0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == A_OUT_GRANT)
        out_grant <= pwdata[N_OUT-1:0];
      if (paddr == A_CUR_GRANT)
        cur_grant <= pwdata[CG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (setup)
    begin
      case (paddr)
        A_OUT_GRANT: prdata <= {{(32-N_OUT){1'b0}}, out_grant};
        A_CUR_GRANT: prdata <= {{(32-CG_W){1'b0}}, cur_grant};
        A_STATUS: prdata <= {16'h0000, status_bits};
        A_FLAGS: prdata <= {16'h0000, flags_n};
        A_RET_PC: prdata <= {{(32-PC_W){1'b0}}, ret_pc};
        A_BDOOR: prdata <= {7'h00, bd_busy, bd_addr_reg, bd_data_reg};
        A_MEAS: prdata <= {19'h00000, dcdc_mode, eoa_mode, irq, asrc_index, dac_mode, adc_q, gain_q, oc_q};
        default: prdata <= '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_flags_unlocked: assert property (@(posedge pclk) disable iff (!presetn)
    core_unlocked |-> flags_n == FLAG_RST) else $error("flags not inactive while unlocked");
  a_flags_write: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd.op == OP_FLAGS && !cmd.single) ##1 !core_unlocked |-> flags_n == $past(cmd.data))
    else $error("flag word not written");
  a_irq_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd.op == OP_IRQ && cmd.data[0]) |=> !host_interrupt_pin_n) else $error("irq pin not low");
  a_pin_any: assert property (@(posedge pclk) disable iff (!presetn)
    (|other_irq) |-> !host_interrupt_pin_n) else $error("irq pin ignores other cores");
  a_jsr_capture: assert property (@(posedge pclk) disable iff (!presetn)
    cmd.op == OP_JSR |=> ret_pc == $past(program_counter)) else $error("return pc not captured");
  a_status_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd.op == OP_STATUS && cmd.single) |=> status_bits[$past(cmd.bit_sel)] == $past(cmd.data[0]))
    else $error("status bit not written");
  a_adc_nocmp: assert property (@(posedge pclk) disable iff (!presetn)
    cm_ctrl.adc_mode |-> !cm_ctrl.thr_cmp_en && !cm_ctrl.oc_4neg) else $error("comparison in adc mode");
  a_oc_4h: assert property (@(posedge pclk) disable iff (!presetn)
    cm_ctrl.oc_4h == cm_ctrl.oc_en[N_CONV-1]) else $error("4h offset mismatch");
  a_bd_twocycle: assert property (@(posedge pclk) disable iff (!presetn)
    (!bd_busy && (cmd.op == OP_BD_RD || cmd.op == OP_BD_WR)) |=> bd_busy [*2] ##1 !bd_busy)
    else $error("backdoor not two cycles");
  a_bd_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (!bd_busy && cmd.op == OP_BD_WR && spi_target_locked) |-> ##1 !bd.we ##1 !bd.we)
    else $error("write to locked target");
  a_bd_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    (!bd_busy && cmd.op == OP_BD_WR && bd_sel_addr == BA_BOOST_DAC) |=> !bd.req)
    else $error("boost threshold reached");
  a_bd_hold: assert property (@(posedge pclk) disable iff (!presetn)
    bd_st == BD_ACT |=> $stable(bd_addr_reg)) else $error("backdoor address moved");
  a_dcdc_grant: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd.op == OP_DCDC && !out_grant[GRANT_LS7]) |=> $stable(dcdc_mode)) else $error("dcdc without grant");
endmodule // mcaux_core

// ### mcaux_regfile_model.sv
`timescale 1ns/1ps
module mcaux_regfile_model
  import mcaux_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mcaux_bd_t bd,
  input wire logic lock_all,
  output logic spi_target_locked,
  output logic [BDD_W-1:0] spi_rdata
);
  logic [BDD_W-1:0] mem [256];
  ////////////////////////////////
  // Lock and read of addressed register
  assign spi_target_locked = lock_all;
  assign spi_rdata = mem[bd.addr];
  ////////////////////////////////
  // Masked field write on strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 256; i++)
      begin
        mem[i] <= {8'h5a, 8'(i)};
      end
    end
    else if (bd.req && bd.we)
    begin
      mem[bd.addr] <= (mem[bd.addr] & ~bd.wmask) | (bd.wdata & bd.wmask);
    end
  end
endmodule // mcaux_regfile_model

// ### mcaux_core_tb.sv
`timescale 1ns/1ps
module mcaux_core_tb
  import mcaux_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mcaux_cmd_t cmd;
  logic [PC_W-1:0] program_counter, ret_pc;
  logic [BDA_W-1:0] index_reg, bd_addr_reg;
  logic core_unlocked, lock_all, spi_target_locked, irq, host_interrupt_pin_n, bd_busy;
  logic [2:0] other_irq;
  logic [15:0] spi_rdata, flags_n, status_bits, bd_data_reg, last_mask;
  mcaux_cm_t cm_ctrl;
  mcaux_bd_t bd;
  logic dcdc_mode, eoa_mode, hs_src_thr_zero;
  int bad_count, check_count;
  mcaux_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmd, .program_counter, .index_reg, .core_unlocked, .other_irq, .spi_target_locked,
    .spi_rdata, .flags_n, .irq, .host_interrupt_pin_n, .ret_pc, .status_bits, .cm_ctrl, .bd,
    .bd_busy, .bd_addr_reg, .bd_data_reg, .dcdc_mode, .eoa_mode, .hs_src_thr_zero);
  mcaux_regfile_model rf (.pclk, .presetn, .bd, .lock_all, .spi_target_locked, .spi_rdata);
  ////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input mcaux_op_t o, input logic s, input logic [3:0] b, input logic [15:0] d);
    @(posedge pclk);
    cmd <= '{o, s, b, d};
    @(posedge pclk);
    cmd.op <= OP_NONE;
  endtask
  // Busy for two cycles, request checked against rq in the first and low in the second
  task automatic bdop(input mcaux_op_t o, input logic [7:0] a, input logic [15:0] d, input logic rq);
    op(OP_BD_ADDR, 1'b0, 4'h0, {8'h00, a});
    op(OP_BD_DATA, 1'b0, 4'h0, d);
    op(o, 1'b0, 4'h0, 16'h0000);
    @(negedge pclk);
    last_mask = bd.wmask;
    chk(bd.req, rq);
    chk(bd_busy, 1'b1);
    @(negedge pclk);
    chk(bd.req, 1'b0);
    chk(bd_busy, 1'b1);
    @(negedge pclk);
    chk(bd_busy, 1'b0);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk(flags_n, 16'hffff);
    chk(host_interrupt_pin_n, 1'b1);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, A_CUR_GRANT, 32'hffffffff);
    apb(1'b0, A_CUR_GRANT, 32'h0);
    chk(rd, 32'h3f);
  endtask
  task automatic t_flags;
    op(OP_FLAGS, 1'b1, 4'h3, 16'h0000);
    @(negedge pclk);
    chk(flags_n, 16'hfff7);
    op(OP_FLAGS, 1'b0, 4'h0, 16'h00ff);
    @(negedge pclk);
    chk(flags_n, 16'h00ff);
    @(posedge pclk);
    core_unlocked <= 1'b1;
    @(negedge pclk);
    chk(flags_n, 16'hffff);
    @(posedge pclk);
    core_unlocked <= 1'b0;
    @(negedge pclk);
    chk(flags_n, 16'h00ff);
  endtask
  task automatic t_irq;
    op(OP_IRQ, 1'b0, 4'h0, 16'h0001);
    @(negedge pclk);
    chk(irq, 1'b1);
    chk(host_interrupt_pin_n, 1'b0);
    op(OP_IRQ, 1'b0, 4'h0, 16'h0000);
    @(negedge pclk);
    chk(host_interrupt_pin_n, 1'b1);
    @(posedge pclk);
    other_irq <= 3'h4;
    @(negedge pclk);
    chk(host_interrupt_pin_n, 1'b0);
    @(posedge pclk);
    other_irq <= 3'h0;
  endtask
  task automatic t_jsr;
    @(posedge pclk);
    program_counter <= 10'h2a5;
    op(OP_JSR, 1'b0, 4'h0, 16'h0000);
    program_counter <= 10'h111;
    @(negedge pclk);
    chk(ret_pc, 10'h2a5);
  endtask
  task automatic t_meas;
    op(OP_OFFC, 1'b0, 4'h0, 16'h0009);
    @(negedge pclk);
    chk(cm_ctrl.oc_en, 4'h9);
    chk({cm_ctrl.oc_4h, cm_ctrl.oc_4neg}, 2'h2);
    op(OP_OFFC, 1'b0, 4'h0, 16'h0007);
    op(OP_GAIN, 1'b0, 4'h0, 16'h0002);
    @(negedge pclk);
    chk(cm_ctrl.oc_4h, 1'b0);
    chk(cm_ctrl.gain, 2'h2);
    op(OP_ADC, 1'b0, 4'h0, 16'h0001);
    @(negedge pclk);
    chk({cm_ctrl.adc_mode, cm_ctrl.thr_cmp_en, cm_ctrl.adc_view}, 3'h4);
    op(OP_DACMODE, 1'b0, 4'h0, {14'h0, DAM_DAC});
    @(negedge pclk);
    chk(cm_ctrl.adc_view, 1'b1);
    op(OP_ADC, 1'b0, 4'h0, 16'h0000);
    @(negedge pclk);
    chk(cm_ctrl.thr_cmp_en, 1'b1);
  endtask
  task automatic t_status;
    op(OP_STATUS, 1'b0, 4'h0, 16'h1234);
    op(OP_STATUS, 1'b1, 4'hf, 16'h0001);
    op(OP_STATUS, 1'b1, 4'h4, 16'h0000);
    apb(1'b0, A_STATUS, 32'h0);
    chk(rd, 32'h9224);
  endtask
  task automatic t_bdoor;
    op(OP_BD_ADDR, 1'b0, 4'h0, 16'h008e);
    op(OP_BD_DATA, 1'b0, 4'h0, 16'hbeef);
    apb(1'b0, A_BDOOR, 32'h0);
    chk(rd, 32'h008ebeef);
    apb(1'b1, A_OUT_GRANT, 32'h1);
    bdop(OP_BD_WR, BA_HS_SLEW, 16'hffff, 1'b1);
    chk(last_mask, 16'h0003);
    bdop(OP_BD_RD, BA_HS_SLEW, 16'h0000, 1'b1);
    chk(bd_data_reg, 16'h5a8f);
    for (int i = 0; i < 6; i++)
    begin
      bdop(OP_BD_RD, BA_DAC_LO + 8'(i), 16'h1111, 1'b0);
      chk(bd_data_reg, 16'h0000);
    end
    bdop(OP_BD_WR, BA_BOOST_DAC, 16'h00ff, 1'b0);
    apb(1'b1, A_CUR_GRANT, 32'h1);
    bdop(OP_BD_WR, BA_CF12, 16'hffff, 1'b1);
    chk(last_mask, 16'h00ff);
    bdop(OP_BD_RD, BA_CF12, 16'h0000, 1'b1);
    chk(bd_data_reg, 16'h5aff);
    @(posedge pclk);
    lock_all <= 1'b1;
    bdop(OP_BD_WR, BA_HS_SLEW, 16'h0000, 1'b0);
    @(posedge pclk);
    lock_all <= 1'b0;
    bdop(OP_BD_RD, BA_HS_SLEW, 16'h0000, 1'b1);
    chk(bd_data_reg, 16'h5a8f);
    @(posedge pclk);
    index_reg <= BA_BIAS;
    op(OP_ASRC, 1'b0, 4'h0, 16'h0001);
    bdop(OP_BD_RD, BA_HS_SLEW, 16'h0000, 1'b1);
    chk(bd_data_reg, 16'h5a88);
  endtask
  task automatic t_cfg;
    op(OP_DCDC, 1'b0, 4'h0, 16'h0001);
    @(negedge pclk);
    chk(dcdc_mode, 1'b0);
    apb(1'b1, A_OUT_GRANT, 32'h801);
    op(OP_DCDC, 1'b0, 4'h0, 16'h0001);
    @(negedge pclk);
    chk(dcdc_mode, 1'b1);
    apb(1'b1, A_CUR_GRANT, 32'h20);
    op(OP_EOA, 1'b0, 4'h0, 16'h0001);
    @(negedge pclk);
    chk({eoa_mode, hs_src_thr_zero}, 2'h3);
    apb(1'b1, A_CUR_GRANT, 32'h0);
    @(negedge pclk);
    chk({eoa_mode, hs_src_thr_zero}, 2'h2);
    apb(1'b0, A_MEAS, 32'h0);
    chk(rd, 32'h00001a27);
  endtask
  ////////////////////////////////
  // Clock, sequence and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, core_unlocked, lock_all} = '0;
    {paddr, pwdata, program_counter, index_reg, other_irq} = '0;
    cmd = '{OP_NONE, 1'b0, 4'h0, 16'h0000};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_jsr();
    t_meas();
    t_status();
    t_bdoor();
    t_cfg();
    print_verdict();
  end
  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule // mcaux_core_tb
